// [bench/fer_link_model.sv]
// Purpose: link controller stand-in that takes frames from the reporter
// Assumes: one acknowledge pulse per request, after STALL waiting cycles
// Notes:   taken frames are queued for the bench to inspect
`default_nettype none
module fer_link_model
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        TX_REQ,
  input  wire logic [10:0] TX_IDENT,
  input  wire logic [3:0]  TX_LEN,
  input  wire logic [63:0] TX_PAYLOAD,
  input  wire logic [7:0]  STALL,
  output logic             TX_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wait_ff;
  logic [10:0] id_q[$];
  logic [3:0]  len_q[$];
  logic [63:0] pl_q[$];
  // ack lasts one cycle so that one request is never taken twice
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      TX_ACK  <= 1'b0;
      wait_ff <= 8'h00;
    end
    else if (TX_ACK)
    begin
      TX_ACK  <= 1'b0;
      wait_ff <= 8'h00;
    end
    else if (TX_REQ)
    begin
      if (wait_ff >= STALL)
        TX_ACK <= 1'b1;
      else
        wait_ff <= wait_ff + 8'h01;
    end
  end
  always @(posedge CLK)
  begin
    if (RSTN && TX_REQ && TX_ACK)
    begin
      id_q.push_back(TX_IDENT);
      len_q.push_back(TX_LEN);
      pl_q.push_back(TX_PAYLOAD);
    end
  end
endmodule // fer_link_model
`default_nettype wire

// [bench/test_fieldbus_emergency_reporter.sv]
// Purpose: self-checking bench for the fieldbus emergency reporter
// Assumes: link model acknowledges frames, bench drives the register port
// Notes:   expected frames are built from the error tables, not the design
`default_nettype none
`define CHK(g, e) check(64'(g), 64'(e))
module test_fieldbus_emergency_reporter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] NODE = 7'h25;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [10:0] err = 11'h0;
  logic [15:0] bus_st = 16'hA1B2;
  logic [15:0] gflags = 16'hC3D4;
  logic [7:0]  mnode = 8'h17;
  logic [7:0]  lcode = 8'h5A;
  logic [7:0]  hcode = 8'h6B;
  logic [63:0] pdo = 64'h0;
  logic [7:0]  stall = 8'h00;
  logic        tx_req;
  logic        tx_ack;
  logic [10:0] tx_id;
  logic [3:0]  tx_len;
  logic [63:0] tx_pl;
  logic [10:0] f_id;
  logic [3:0]  f_len;
  logic [63:0] f_pl;
  logic [31:0] rv;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  fer_reporter #(.PDO_BITS(64)) i_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ERR_ACTIVE(err), .BUS_STATE(bus_st),
    .GLOBAL_FLAGS(gflags), .MODULE_NODE(mnode), .LINK_ERR_CODE(lcode),
    .HANDLER_ERR_CODE(hcode), .PDO_VALUES(pdo), .TX_REQ(tx_req), .TX_ACK(tx_ack),
    .TX_IDENT(tx_id), .TX_LEN(tx_len), .TX_PAYLOAD(tx_pl));
  fer_link_model i_link (.CLK(clk), .RSTN(rstn), .TX_REQ(tx_req), .TX_IDENT(tx_id),
    .TX_LEN(tx_len), .TX_PAYLOAD(tx_pl), .STALL(stall), .TX_ACK(tx_ack));

  always #20 clk = ~clk;

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard: whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // polls on the falling edge, clear of the model's capture
  task automatic get_frame;
    for (int i = 0; i < 300 && i_link.id_q.size() == 0; i++)
      @(negedge clk);
    if (i_link.id_q.size() == 0)
      `CHK(0, 1);
    else
    begin
      f_id  = i_link.id_q.pop_front();
      f_len = i_link.len_q.pop_front();
      f_pl  = i_link.pl_q.pop_front();
    end
  endtask

  task automatic drain;
    repeat (40) @(posedge clk);
    i_link.id_q.delete();
    i_link.len_q.delete();
    i_link.pl_q.delete();
  endtask

  function automatic logic [15:0] exp_code(input int s);
    case (s)
      5: return 16'h8140;
      7: return 16'h8130;
      8: return 16'h8210;
      9: return 16'h8110;
      10: return 16'h8120;
      default: return 16'hFF00;
    endcase
  endfunction

  // detail byte then four parameter bytes, as payload bits 63:24
  function automatic logic [39:0] exp_tail(input int s);
    case (s)
      0: return {gflags, bus_st, 8'h01};
      1: return {gflags, bus_st, 8'h02};
      2: return {gflags, bus_st, 8'h03};
      3: return {24'h0, mnode, 8'h05};
      4: return {32'h0, 8'h06};
      5: return {24'h0, lcode, 8'h80};
      6: return {24'h0, hcode, 8'h81};
      7: return {32'h0, 8'h82};
      8: return {32'h0, 8'h83};
      default: return {24'h0, lcode, 8'h80};
    endcase
  endfunction

  task automatic t_regs;
    rreg(fer_pkg::REG_SUMMARY_OFS, rv);
    `CHK(rv, 32'h0);
    rreg(fer_pkg::REG_PDO_TYPE_OFS, rv);
    `CHK(rv, 32'hFF);
    wreg(fer_pkg::REG_SUMMARY_OFS, 32'hFF);
    rreg(fer_pkg::REG_SUMMARY_OFS, rv);
    `CHK(rv, 32'h0);
    rreg(8'h14, rv);
    `CHK(rv, 32'h0);
    wreg(fer_pkg::REG_NODE_OFS, {25'h0, NODE});
    rreg(fer_pkg::REG_NODE_OFS, rv);
    `CHK(rv[6:0], NODE);
  endtask

  task automatic t_pdo;
    @(posedge clk);
    pdo <= 64'h0123456789ABCDEF;
    get_frame();
    `CHK({f_id, f_len, f_pl}, {11'h180 + {4'h0, NODE}, 4'h8, 64'h0123456789ABCDEF});
    wreg(fer_pkg::REG_PDO_TYPE_OFS, 32'hFE);
    pdo <= 64'h1111;
    repeat (30) @(posedge clk);
    `CHK(i_link.id_q.size(), 0);
    wreg(fer_pkg::REG_PDO_TYPE_OFS, 32'hFF);
    drain();
  endtask

  task automatic t_sources;
    for (int s = 0; s < 11; s++)
    begin
      @(posedge clk);
      err[s] <= 1'b1;
      get_frame();
      `CHK({f_id, f_len}, {11'h080 + {4'h0, NODE}, 4'h8});
      `CHK(f_pl[15:0], exp_code(s));
      `CHK(f_pl[23:16], (s inside {5, 7, 8, 9, 10}) ? 8'h11 : 8'h81);
      if (s < 9)
        `CHK(f_pl[63:24], exp_tail(s));
      if (s >= 9)
        `CHK(f_pl[63:24], exp_tail(s));
      rreg(fer_pkg::REG_SUMMARY_OFS, rv);
      `CHK(rv, (s inside {5, 7, 8, 9, 10}) ? 32'h11 : 32'h81);
      rreg(fer_pkg::REG_LAST_CODE_OFS, rv);
      `CHK(rv[15:0], exp_code(s));
      repeat (20) @(posedge clk);
      `CHK(i_link.id_q.size(), 0);
      err[s] <= 1'b0;
      get_frame();
      `CHK(f_pl[23:0], 24'h0);
    end
  endtask

  task automatic t_keep;
    @(posedge clk);
    err[0] <= 1'b1;
    get_frame();
    @(posedge clk);
    err[7] <= 1'b1;
    get_frame();
    @(posedge clk);
    err[7] <= 1'b0;
    get_frame();
    `CHK(f_pl[23:0], 24'h810000);
    rreg(fer_pkg::REG_SUMMARY_OFS, rv);
    `CHK(rv, 32'h81);
    @(posedge clk);
    err[0] <= 1'b0;
    get_frame();
    `CHK(f_pl[23:0], 24'h0);
  endtask

  // slow link keeps a pdo waiting while an emergency arrives
  task automatic t_priority;
    @(posedge clk);
    stall <= 8'd40;
    pdo   <= 64'h5555;
    for (int i = 0; i < 50 && tx_req !== 1'b1; i++)
      @(negedge clk);
    @(posedge clk);
    pdo    <= 64'hAAAA;
    err[3] <= 1'b1;
    get_frame();
    `CHK(f_id, 11'h180 + {4'h0, NODE});
    get_frame();
    `CHK(f_id, 11'h080 + {4'h0, NODE});
    @(posedge clk);
    stall  <= 8'h00;
    err[3] <= 1'b0;
    drain();
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pdo();
    t_sources();
    t_keep();
    t_priority();
    end_sim();
  end
endmodule // test_fieldbus_emergency_reporter
`default_nettype wire

// [design/fer_arbiter.sv]
// Purpose: picks one of two frame sources, emergency first
// Assumes: each source holds its request until acknowledged
// Notes:   fixed priority; an emergency still waits for a pdo frame already granted to be acknowledged
`default_nettype none
module fer_arbiter
(
  input  wire logic CLK,
  input  wire logic RSTN,
  fer_frame_if.snk  emcy,
  fer_frame_if.snk  pdo,
  fer_frame_if.src  out
);
  logic sel_emcy_ff;
  logic busy_ff;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      busy_ff     <= 1'b0;
      sel_emcy_ff <= 1'b0;
    end
    else if (!busy_ff && (emcy.req || pdo.req))
    begin
      busy_ff     <= 1'b1;
      sel_emcy_ff <= emcy.req;
    end
    else if (busy_ff && out.ack)
    begin
      busy_ff <= 1'b0;
    end
  end

  assign out.req     = busy_ff;
  assign out.ident   = sel_emcy_ff ? emcy.ident : pdo.ident;
  assign out.len     = sel_emcy_ff ? emcy.len : pdo.len;
  assign out.payload = sel_emcy_ff ? emcy.payload : pdo.payload;
  assign emcy.ack    = busy_ff && sel_emcy_ff && out.ack;
  assign pdo.ack     = busy_ff && !sel_emcy_ff && out.ack;

  // emergency waiting at grant time always wins
  property p_emcy_first;
    @(posedge CLK) disable iff (!RSTN)
      (!busy_ff && emcy.req) |=> (busy_ff && sel_emcy_ff);
  endproperty
  a_emcy_first: assert property (p_emcy_first) else $error("pdo granted over emergency");
  c_pdo_grant: cover property (@(posedge CLK) disable iff (!RSTN) pdo.ack);
endmodule : fer_arbiter
`default_nettype wire

// [design/fer_frame_if.sv]
// Purpose: frame request carrier between the framer and its sender
// Assumes: request held until accepted
// Notes:   payload byte 0 is sent first
`default_nettype none
interface fer_frame_if;
  logic        req;
  logic        ack;
  logic [10:0] ident;
  logic [3:0]  len;
  logic [63:0] payload;
  modport src (output req, output ident, output len, output payload, input ack);
  modport snk (input req, input ident, input len, input payload, output ack);
endinterface : fer_frame_if
`default_nettype wire

// [design/fer_pkg.sv]
// Purpose: shared constants and types for the fieldbus emergency reporter
// Assumes: single clock, whole frames on a request/acknowledge port toward the link controller
// Notes:   offsets are word byte addresses on the plain register port
`default_nettype none
package fer_pkg;
  localparam logic [7:0]  REG_SUMMARY_OFS   = 8'h00;
  localparam logic [7:0]  REG_LAST_CODE_OFS = 8'h04;
  localparam logic [7:0]  REG_NODE_OFS      = 8'h08;
  localparam logic [7:0]  REG_STATUS_OFS    = 8'h0C;
  localparam logic [7:0]  REG_PDO_TYPE_OFS  = 8'h10;
  localparam logic [10:0] EMCY_BASE_ID      = 11'h080;
  localparam logic [10:0] PDO_BASE_ID       = 11'h180;
  localparam logic [7:0]  PDO_TYPE_RST      = 8'hFF;
  localparam logic [6:0]  NODE_RST          = 7'h01;
  localparam logic [3:0]  EMCY_LEN          = 4'h8;
  localparam int          SUM_GENERIC_BIT   = 0;
  localparam int          SUM_COMM_BIT      = 4;
  localparam int          SUM_MFR_BIT       = 7;
  localparam logic [7:0]  SUM_USED_MASK     = 8'h91;
  localparam logic [15:0] CODE_RECOVERY     = 16'h0000;
  localparam logic [15:0] CODE_OVERRUN      = 16'h8110;
  localparam logic [15:0] CODE_ERR_PASSIVE  = 16'h8120;
  localparam logic [15:0] CODE_GUARD        = 16'h8130;
  localparam logic [15:0] CODE_BUSOFF_RECOV = 16'h8140;
  localparam logic [15:0] CODE_PDO_LEN      = 16'h8210;
  localparam logic [15:0] CODE_DEVICE       = 16'hFF00;
  localparam logic [7:0]  DET_FATAL         = 8'h01;
  localparam logic [7:0]  DET_STATE_EXC     = 8'h02;
  localparam logic [7:0]  DET_PASSIVE       = 8'h03;
  localparam logic [7:0]  DET_FWD           = 8'h05;
  localparam logic [7:0]  DET_TOOL          = 8'h06;
  localparam logic [7:0]  DET_DLL           = 8'h80;
  localparam logic [7:0]  DET_HANDLER       = 8'h81;
  localparam logic [7:0]  DET_GUARD         = 8'h82;
  localparam logic [7:0]  DET_SHORT_PDO     = 8'h83;
  localparam int          NUM_SRC           = 11;
  // event sources, one bit each on the error input vectors
  typedef enum logic [3:0] {
    SRC_FATAL, SRC_STATE_EXC, SRC_PASSIVE, SRC_FWD, SRC_TOOL, SRC_DLL,
    SRC_HANDLER, SRC_GUARD, SRC_SHORT_PDO, SRC_OVERRUN, SRC_ERR_PASSIVE
  } fer_src_t;
endpackage : fer_pkg
`default_nettype wire

// [design/fer_reporter.sv]
// Purpose: builds emergency and event-driven pdo frames for the fieldbus
// Assumes: error inputs are levels from same-clock logic; frames leave on
//          a request/acknowledge port toward the link controller
// Notes:   one pending raise and one pending recovery per source; lowest source index sent first
`default_nettype none
module fer_reporter
#(
  parameter int PDO_BITS = 64
)
(
  input  wire logic                        CLK,
  input  wire logic                        RSTN,
  input  wire logic [7:0]                  ADDR,
  input  wire logic [31:0]                 WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [31:0]                 RDATA,
  input  wire logic [fer_pkg::NUM_SRC-1:0] ERR_ACTIVE,
  input  wire logic [15:0]                 BUS_STATE,
  input  wire logic [15:0]                 GLOBAL_FLAGS,
  input  wire logic [7:0]                  MODULE_NODE,
  input  wire logic [7:0]                  LINK_ERR_CODE,
  input  wire logic [7:0]                  HANDLER_ERR_CODE,
  input  wire logic [PDO_BITS-1:0]         PDO_VALUES,
  output logic                             TX_REQ,
  input  wire logic                        TX_ACK,
  output logic      [10:0]                 TX_IDENT,
  output logic      [3:0]                  TX_LEN,
  output logic      [63:0]                 TX_PAYLOAD
);
  localparam int NS = fer_pkg::NUM_SRC;

  fer_frame_if emcy_if ();
  fer_frame_if pdo_if ();
  fer_frame_if out_if ();

  logic [NS-1:0]       err_prev_ff;
  logic [NS-1:0]       raise_pend_ff;
  logic [NS-1:0]       clear_pend_ff;
  logic [6:0]          node_ff;
  logic [7:0]          pdo_type_ff;
  logic [15:0]         last_code_ff;
  logic [31:0]         rdata_ff;
  logic [PDO_BITS-1:0] pdo_prev_ff;
  logic                pdo_pend_ff;
  logic                emcy_busy_ff;
  logic [63:0]         emcy_payload_ff;
  logic [3:0]          emcy_src_ff;
  logic                emcy_clear_ff;
  logic [NS-1:0]       rise;
  logic [NS-1:0]       fall;
  logic [7:0]          summary;
  logic                any_pend;
  logic [3:0]          pick;
  logic                pick_clear;

  // communication-class sources feed bit 4, everything else bit 7
  function automatic logic is_comm(input logic [3:0] s);
    case (s)
      fer_pkg::SRC_DLL, fer_pkg::SRC_GUARD, fer_pkg::SRC_SHORT_PDO,
      fer_pkg::SRC_OVERRUN, fer_pkg::SRC_ERR_PASSIVE: is_comm = 1'b1;
      default: is_comm = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] code_of(input logic [3:0] s);
    case (s)
      fer_pkg::SRC_OVERRUN:     code_of = fer_pkg::CODE_OVERRUN;
      fer_pkg::SRC_ERR_PASSIVE: code_of = fer_pkg::CODE_ERR_PASSIVE;
      fer_pkg::SRC_DLL:         code_of = fer_pkg::CODE_BUSOFF_RECOV;
      fer_pkg::SRC_GUARD:       code_of = fer_pkg::CODE_GUARD;
      fer_pkg::SRC_SHORT_PDO:   code_of = fer_pkg::CODE_PDO_LEN;
      default:                  code_of = fer_pkg::CODE_DEVICE;
    endcase
  endfunction

  function automatic logic [7:0] detail_of(input logic [3:0] s);
    case (s)
      fer_pkg::SRC_FATAL:     detail_of = fer_pkg::DET_FATAL;
      fer_pkg::SRC_STATE_EXC: detail_of = fer_pkg::DET_STATE_EXC;
      fer_pkg::SRC_PASSIVE:   detail_of = fer_pkg::DET_PASSIVE;
      fer_pkg::SRC_FWD:       detail_of = fer_pkg::DET_FWD;
      fer_pkg::SRC_TOOL:      detail_of = fer_pkg::DET_TOOL;
      fer_pkg::SRC_HANDLER:   detail_of = fer_pkg::DET_HANDLER;
      fer_pkg::SRC_GUARD:     detail_of = fer_pkg::DET_GUARD;
      fer_pkg::SRC_SHORT_PDO: detail_of = fer_pkg::DET_SHORT_PDO;
      default:                detail_of = fer_pkg::DET_DLL;
    endcase
  endfunction

  // four parameter bytes, byte four first in the low byte
  function automatic logic [31:0] params_of(input logic [3:0] s, input logic [15:0] st,
                                            input logic [15:0] gf, input logic [7:0] mn,
                                            input logic [7:0] lc, input logic [7:0] hc);
    case (s)
      fer_pkg::SRC_FATAL, fer_pkg::SRC_STATE_EXC, fer_pkg::SRC_PASSIVE:
        params_of = {gf[15:8], gf[7:0], st[15:8], st[7:0]};
      fer_pkg::SRC_FWD:     params_of = {24'h000000, mn};
      fer_pkg::SRC_DLL, fer_pkg::SRC_OVERRUN, fer_pkg::SRC_ERR_PASSIVE:
        params_of = {24'h000000, lc};
      fer_pkg::SRC_HANDLER: params_of = {24'h000000, hc};
      default:              params_of = 32'h00000000;
    endcase
  endfunction

  assign rise = ERR_ACTIVE & ~err_prev_ff;
  assign fall = ~ERR_ACTIVE & err_prev_ff;

  // summary byte straight from live error levels
  always_comb
  begin
    summary = 8'h00;
    summary[fer_pkg::SUM_GENERIC_BIT] = |ERR_ACTIVE;
    for (int i = 0; i < NS; i++)
    begin
      if (ERR_ACTIVE[i] && is_comm(4'(i)))
        summary[fer_pkg::SUM_COMM_BIT] = 1'b1;
      if (ERR_ACTIVE[i] && !is_comm(4'(i)))
        summary[fer_pkg::SUM_MFR_BIT] = 1'b1;
    end
    summary = summary & fer_pkg::SUM_USED_MASK;
  end

  // priority pick among pending raises and recoveries
  always_comb
  begin
    any_pend   = 1'b0;
    pick       = 4'h0;
    pick_clear = 1'b0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (raise_pend_ff[i] || clear_pend_ff[i])
      begin
        any_pend   = 1'b1;
        pick       = 4'(i);
        pick_clear = !raise_pend_ff[i];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      err_prev_ff <= '0;
    else
      err_prev_ff <= ERR_ACTIVE;
  end

  // new edge sets pending; set wins over the clear of a launched frame
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      raise_pend_ff <= '0;
      clear_pend_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < NS; i++)
      begin
        if (rise[i])
          raise_pend_ff[i] <= 1'b1;
        else if (!emcy_busy_ff && any_pend && pick == 4'(i) && !pick_clear)
          raise_pend_ff[i] <= 1'b0;
        if (fall[i])
          clear_pend_ff[i] <= 1'b1;
        else if (rise[i] || (!emcy_busy_ff && any_pend && pick == 4'(i) && pick_clear))
          clear_pend_ff[i] <= 1'b0;
      end
    end
  end

  // payload snapshot at launch so it stays stable while waiting; the identifier follows node_ff live
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      emcy_busy_ff    <= 1'b0;
      emcy_payload_ff <= 64'h0000000000000000;
      emcy_src_ff     <= 4'h0;
      emcy_clear_ff   <= 1'b0;
      last_code_ff    <= 16'h0000;
    end
    else if (!emcy_busy_ff && any_pend)
    begin
      emcy_busy_ff  <= 1'b1;
      emcy_src_ff   <= pick;
      emcy_clear_ff <= pick_clear;
      last_code_ff  <= pick_clear ? fer_pkg::CODE_RECOVERY : code_of(pick);
      emcy_payload_ff <= {params_of(pick, BUS_STATE, GLOBAL_FLAGS, MODULE_NODE,
                                    LINK_ERR_CODE, HANDLER_ERR_CODE),
                          detail_of(pick), summary,
                          pick_clear ? fer_pkg::CODE_RECOVERY : code_of(pick)};
    end
    else if (emcy_busy_ff && emcy_if.ack)
      emcy_busy_ff <= 1'b0;
  end

  assign emcy_if.req     = emcy_busy_ff;
  assign emcy_if.ident   = fer_pkg::EMCY_BASE_ID + {4'h0, node_ff};
  assign emcy_if.len     = fer_pkg::EMCY_LEN;
  assign emcy_if.payload = emcy_payload_ff;

  // event-driven pdo: any change of the mapped values queues one frame
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pdo_prev_ff <= '0;
      pdo_pend_ff <= 1'b0;
    end
    else
    begin
      pdo_prev_ff <= PDO_VALUES;
      if (PDO_VALUES != pdo_prev_ff && pdo_type_ff == fer_pkg::PDO_TYPE_RST)
        pdo_pend_ff <= 1'b1;
      else if (pdo_if.ack)
        pdo_pend_ff <= 1'b0;
    end
  end

  // pdo data are sampled live; the newest value goes out
  assign pdo_if.req     = pdo_pend_ff;
  assign pdo_if.ident   = fer_pkg::PDO_BASE_ID + {4'h0, node_ff};
  assign pdo_if.len     = fer_pkg::EMCY_LEN;
  assign pdo_if.payload = 64'(pdo_prev_ff);

  fer_arbiter u_arb
  (
    .CLK  (CLK),
    .RSTN (RSTN),
    .emcy (emcy_if.snk),
    .pdo  (pdo_if.snk),
    .out  (out_if.src)
  );

  assign TX_REQ      = out_if.req;
  assign TX_IDENT    = out_if.ident;
  assign TX_LEN      = out_if.len;
  assign TX_PAYLOAD  = out_if.payload;
  assign out_if.ack  = TX_ACK;

  // register writes
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      node_ff     <= fer_pkg::NODE_RST;
      pdo_type_ff <= fer_pkg::PDO_TYPE_RST;
    end
    else if (WR)
    begin
      if (ADDR == fer_pkg::REG_NODE_OFS)
        node_ff <= WDATA[6:0];
      if (ADDR == fer_pkg::REG_PDO_TYPE_OFS)
        pdo_type_ff <= WDATA[7:0];
    end
  end

  // register reads, one cycle later; unmapped reads zero
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_ff <= 32'h00000000;
    else if (RD)
    begin
      case (ADDR)
        fer_pkg::REG_SUMMARY_OFS:   rdata_ff <= {24'h000000, summary};
        fer_pkg::REG_LAST_CODE_OFS: rdata_ff <= {16'h0000, last_code_ff};
        fer_pkg::REG_NODE_OFS:      rdata_ff <= {25'h0000000, node_ff};
        fer_pkg::REG_STATUS_OFS:
          rdata_ff <= {19'h00000, pdo_pend_ff, emcy_busy_ff, NS'(raise_pend_ff)};
        fer_pkg::REG_PDO_TYPE_OFS:  rdata_ff <= {24'h000000, pdo_type_ff};
        default:                    rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  end

  assign RDATA = rdata_ff;

  property p_one_per_event;
    @(posedge CLK) disable iff (!RSTN)
      (emcy_if.ack && !emcy_clear_ff && !rise[emcy_src_ff])
        |=> !raise_pend_ff[emcy_src_ff];
  endproperty
  a_one_per_event: assert property (p_one_per_event) else $error("event sent twice");

  property p_len_eight;
    @(posedge CLK) disable iff (!RSTN)
      emcy_if.req |-> emcy_if.len == 4'h8;
  endproperty
  a_len_eight: assert property (p_len_eight) else $error("emergency length not eight");

  property p_ident;
    @(posedge CLK) disable iff (!RSTN)
      TX_REQ && u_arb.sel_emcy_ff |-> TX_IDENT == 11'h080 + {4'h0, node_ff};
  endproperty
  a_ident: assert property (p_ident) else $error("emergency identifier wrong");

  property p_recovery_code;
    @(posedge CLK) disable iff (!RSTN)
      emcy_busy_ff && emcy_clear_ff |-> emcy_payload_ff[15:0] == 16'h0000;
  endproperty
  a_recovery_code: assert property (p_recovery_code) else $error("recovery code not zero");

  property p_summary_bits;
    @(posedge CLK) disable iff (!RSTN)
      (summary[0] == |ERR_ACTIVE) && (summary & 8'h6E) == 8'h00;
  endproperty
  a_summary_bits: assert property (p_summary_bits) else $error("summary bits wrong");

  // summary as it stood at launch, for the frame check one cycle later
  logic [7:0] summary_d;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      summary_d <= 8'h00;
    else
      summary_d <= summary;
  end
  property p_guard_frame;
    @(posedge CLK) disable iff (!RSTN)
      (!emcy_busy_ff && any_pend && !pick_clear && pick == fer_pkg::SRC_GUARD)
        |=> emcy_payload_ff[31:0] == {8'h82, summary_d, 16'h8130}
            && emcy_payload_ff[63:32] == 32'h00000000;
  endproperty
  a_guard_frame: assert property (p_guard_frame) else $error("guard frame fields wrong");

  property p_pdo_change;
    @(posedge CLK) disable iff (!RSTN)
      (PDO_VALUES != pdo_prev_ff && pdo_type_ff == 8'hFF) |=> pdo_pend_ff;
  endproperty
  a_pdo_change: assert property (p_pdo_change) else $error("pdo change not queued");

  property p_fwd_params;
    @(posedge CLK) disable iff (!RSTN)
      (!emcy_busy_ff && any_pend && !pick_clear && pick == fer_pkg::SRC_FWD)
        |=> emcy_payload_ff[31:24] == 8'h05 && emcy_payload_ff[63:40] == 24'h000000;
  endproperty
  a_fwd_params: assert property (p_fwd_params) else $error("forward frame fields wrong");

  c_emcy_sent: cover property (@(posedge CLK) disable iff (!RSTN) emcy_if.ack && !emcy_clear_ff);
  c_recovery:  cover property (@(posedge CLK) disable iff (!RSTN) emcy_if.ack && emcy_clear_ff);
  c_both_pend: cover property (@(posedge CLK) disable iff (!RSTN) emcy_if.req && pdo_if.req);
endmodule : fer_reporter
`default_nettype wire
